// file: csb_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module csb_pin_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pins and filtered level
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once two stages agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pin_level[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        pin_level[i] <= s3_q[i];
      end
    end
  end

endmodule : csb_pin_sync

// file: csb_pkg.sv
// Shared constants and types for the core special function register bank
package csb_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_INDIRECT = 4'h4;
  localparam logic [3:0] IDX_PORT = 4'h6;
  localparam logic [3:0] IDX_POWER = 4'h8;
  localparam logic [3:0] IDX_WAKE = 4'h9;
  localparam logic [3:0] IDX_PC_HIGH_BUFFER = 4'ha;
  localparam logic [3:0] IDX_PULLDN = 4'hb;

  // Flags register fields
  localparam int FLG_CARRY = 0;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SLEEP_N = 3;
  localparam int FLG_WDT_N = 4;
  localparam int FLG_SPARE = 5;
  localparam int FLG_BANK_LO = 6;
  localparam int FLG_BANK_HI = 7;

  // Power control fields
  localparam int PWR_LOCK = 0;
  localparam int PWR_TOERR = 1;
  localparam int PWR_SPARE2 = 2;
  localparam int PWR_LVR = 3;
  localparam int PWR_SPARE4 = 4;
  localparam int PWR_LVD = 5;
  localparam int PWR_SPARE6 = 6;
  localparam int PWR_WDT = 7;

  // Other field positions
  localparam int IND_SPARE = 7;
  localparam int PCH_SPARE = 7;
  localparam int PULLDN_LSB = 4;
  localparam int PORT_SPARE_LSB = 6;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h18;
  localparam logic [7:0] INDIRECT_RST = 8'h00;
  localparam logic [5:0] PORT_LATCH_RST = 6'h00;
  localparam logic [1:0] PORT_SPARE_RST = 2'h0;
  localparam logic [7:0] POWER_RST = 8'h89;
  localparam logic [5:0] WAKE_RST = 6'h3f;
  localparam logic [2:0] PC_HIGH_BUFFER_RST = 3'h0;
  localparam logic [3:0] PULLDN_RST = 4'hf;
  localparam logic [1:0] PC_HI_RST = 2'h0;

  // Nonvolatile unlock sequence
  localparam logic [7:0] UNLOCK_CODE1 = 8'hc9;
  localparam logic [7:0] UNLOCK_CODE2 = 8'h3a;
  localparam logic [7:0] UNLOCK_CODE3 = 8'hd3;

  typedef enum logic [1:0] {CSB_OP_ADD, CSB_OP_SUB, CSB_OP_LOGIC} csb_alu_op_e;
  typedef enum logic [1:0] {CSB_LK_LOCKED, CSB_LK_CODE1, CSB_LK_CODE2, CSB_LK_OPEN} csb_lock_e;

  typedef struct packed {
    logic valid;
    csb_alu_op_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] logic_res;
  } csb_alu_req_s;

  typedef struct packed {
    logic [1:0] bank_select;
    logic [6:0] indirect_index;
    logic watchdog_enable;
    logic low_voltage_detect_enable;
    logic low_voltage_reset_enable;
    logic [5:0] pin_wakeup_bit;
    logic [3:0] pulldown_off_bit;
  } csb_ctrl_s;

endpackage : csb_pkg

// file: csb_sfr_bank.sv
// Core special function register bank: flags, pointer, port, power and pin control
// Functional notes
// - Carry set on add carry-out or subtract no-borrow, else cleared.
// - Nibble carry set on carry out of bit 3, or no borrow from it.
// - Zero flag set when the operation result is zero, else cleared.
// - Sleep flag (low) reads 1 after reset or watchdog clear, 0 on sleep.
// - Watchdog flag (low) 1 after reset, clear or sleep; 0 on timeout.
// - Two-bit bank select in top flags bits, read/write, resets to zero.
// - Pointer low seven bits index 128 registers; bit 7 spare storage.
// - Port read gives pin for inputs; output pins pin or latch per option.
// - Port write loads output latches; upper two bits are spare storage.
// - Power enables: watchdog bit 7 resets 1, detector 5 resets 0, reset 3 resets 1.
// - Read-only bit 1 shows write timeout, only with option enabled; resets 0.
// - Read-only bit 0 shows write lock state; resets to 1 (locked).
// - Six wake-up enables for pins 0 to 5 reset to 1; top bits unimplemented.
// - Buffer low bits hold program counter bits 9:8, reset 00; bit 7 spare.
// - Pull-low bits 7:4 disable resistors of pins 3:0 when 1; reset to 1.
// - Spare storage bits keep and return software writes with no side effect.
// - Program counter bits 9:8 load only from the buffer on a counter load.
// - Unlock needs codes c9, 3a, d3 in turn before a write is accepted.
`timescale 1ns/10ps
module csb_sfr_bank
  import csb_pkg::*;
#(
  parameter int PIN_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core execution events
  input wire csb_alu_req_s alu_req,
  input wire logic sleep_exec,
  input wire logic watchdog_clear_instruction,
  input wire logic wdt_timeout,
  input wire logic pc_load,
  output logic [1:0] pc_high_bits,
  output logic [7:0] flags_out,
  // Port pins
  input wire logic [PIN_W-1:0] pin_in,
  input wire logic [PIN_W-1:0] pin_out_en,
  input wire logic port_readback_option,
  output logic [PIN_W-1:0] port_latch,
  // Nonvolatile write linkage
  input wire logic nvm_timeout_option,
  input wire logic nvm_timeout_event,
  input wire logic nvm_unlock_code_write,
  input wire logic [7:0] nvm_unlock_code,
  input wire logic nvm_write_instruction,
  output logic nvm_write_accept,
  // Control outputs
  output csb_ctrl_s ctrl
);

  function automatic logic hit(input logic [5:0] addr, input logic [3:0] idx);
    hit = (addr[5:2] == idx);
  endfunction : hit

  logic [7:0] flags_q;
  logic [7:0] indirect_q;
  logic [1:0] port_spare_q;
  logic [7:0] power_q;
  logic [5:0] power_rw_q;
  logic [5:0] wake_q;
  logic [2:0] pc_high_buffer_q;
  logic [3:0] pulldn_q;
  logic toerr_q;
  csb_lock_e lock_q;
  logic rd_ack_q;
  logic [PIN_W-1:0] pin_level;
  logic wr_en;
  logic [7:0] wd;
  logic [7:0] rd_d;
  logic [7:0] b_eff;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] result;
  logic [PIN_W-1:0] latch_sel;

  csb_pin_sync #(.W(PIN_W)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_async(pin_in),
    .pin_level(pin_level)
  );

  assign wr_en = avs_write & avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  // One wait state on reads so read data come from a flop
  assign avs_waitrequest = avs_read & ~rd_ack_q;

  // Arithmetic: subtract as add of complement, so carry means no borrow
  always_comb begin
    cin = (alu_req.op == CSB_OP_SUB);
    b_eff = cin ? ~alu_req.b : alu_req.b;
    sum9 = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, cin};
    nib5 = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    result = (alu_req.op == CSB_OP_LOGIC) ? alu_req.logic_res : sum9[7:0];
  end

  // Arithmetic flags; a hardware update beats a same-cycle software write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q[FLG_ZERO:FLG_CARRY] <= FLAGS_RST[FLG_ZERO:FLG_CARRY];
    end else if (alu_req.valid) begin
      if (alu_req.op != CSB_OP_LOGIC) begin
        flags_q[FLG_CARRY] <= sum9[8];
        flags_q[FLG_NIBBLE] <= nib5[4];
      end
      flags_q[FLG_ZERO] <= (result == 8'h00);
    end else if (wr_en && hit(avs_address, IDX_FLAGS)) begin
      flags_q[FLG_ZERO:FLG_CARRY] <= wd[FLG_ZERO:FLG_CARRY];
    end
  end

  // Reset-cause flags; events win over software writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q[FLG_SLEEP_N] <= FLAGS_RST[FLG_SLEEP_N];
      flags_q[FLG_WDT_N] <= FLAGS_RST[FLG_WDT_N];
    end else begin
      if (sleep_exec) begin
        flags_q[FLG_SLEEP_N] <= 1'b0;
      end else if (watchdog_clear_instruction) begin
        flags_q[FLG_SLEEP_N] <= 1'b1;
      end else if (wr_en && hit(avs_address, IDX_FLAGS)) begin
        flags_q[FLG_SLEEP_N] <= wd[FLG_SLEEP_N];
      end
      if (wdt_timeout) begin
        flags_q[FLG_WDT_N] <= 1'b0;
      end else if (sleep_exec || watchdog_clear_instruction) begin
        flags_q[FLG_WDT_N] <= 1'b1;
      end else if (wr_en && hit(avs_address, IDX_FLAGS)) begin
        flags_q[FLG_WDT_N] <= wd[FLG_WDT_N];
      end
    end
  end

  // Bank select and spare bit of the flags register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q[FLG_BANK_HI:FLG_SPARE] <= FLAGS_RST[FLG_BANK_HI:FLG_SPARE];
    end else if (wr_en && hit(avs_address, IDX_FLAGS)) begin
      flags_q[FLG_BANK_HI:FLG_SPARE] <= wd[FLG_BANK_HI:FLG_SPARE];
    end
  end

  // Indirect pointer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      indirect_q <= INDIRECT_RST;
    end else if (wr_en && hit(avs_address, IDX_INDIRECT)) begin
      indirect_q <= wd;
    end
  end

  // Port output latches and spare bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_latch <= PORT_LATCH_RST;
      port_spare_q <= PORT_SPARE_RST;
    end else if (wr_en && hit(avs_address, IDX_PORT)) begin
      port_latch <= wd[PIN_W-1:0];
      port_spare_q <= wd[7:PORT_SPARE_LSB];
    end
  end

  // Output pins show the latch only when the option picks it
  assign latch_sel = pin_out_en & {PIN_W{port_readback_option}};

  // Power control writable bits; bits 1:0 are never written by software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      power_rw_q <= POWER_RST[7:2];
    end else if (wr_en && hit(avs_address, IDX_POWER)) begin
      power_rw_q <= wd[7:2];
    end
  end

  // Write timeout flag; a new accepted write clears it, the event wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      toerr_q <= POWER_RST[PWR_TOERR];
    end else if (nvm_timeout_event && nvm_timeout_option) begin
      toerr_q <= 1'b1;
    end else if (nvm_write_accept) begin
      toerr_q <= 1'b0;
    end
  end

  // Unlock sequence; any wrong code starts over
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_q <= CSB_LK_LOCKED;
    end else if (nvm_write_accept) begin
      lock_q <= CSB_LK_LOCKED;
    end else if (nvm_unlock_code_write) begin
      case (lock_q)
        CSB_LK_CODE1: begin
          lock_q <= (nvm_unlock_code == UNLOCK_CODE2) ? CSB_LK_CODE2 : CSB_LK_LOCKED;
        end
        CSB_LK_CODE2: begin
          lock_q <= (nvm_unlock_code == UNLOCK_CODE3) ? CSB_LK_OPEN : CSB_LK_LOCKED;
        end
        default: begin
          lock_q <= (nvm_unlock_code == UNLOCK_CODE1) ? CSB_LK_CODE1 : CSB_LK_LOCKED;
        end
      endcase
    end
  end

  assign nvm_write_accept = nvm_write_instruction & (lock_q == CSB_LK_OPEN);
  assign power_q = {power_rw_q, toerr_q, (lock_q != CSB_LK_OPEN)};

  // Wake-up and pull-low controls
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= WAKE_RST;
      pulldn_q <= PULLDN_RST;
    end else if (wr_en) begin
      if (hit(avs_address, IDX_WAKE)) begin
        wake_q <= wd[5:0];
      end else if (hit(avs_address, IDX_PULLDN)) begin
        pulldn_q <= wd[7:PULLDN_LSB];
      end
    end
  end

  // Program counter high buffer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pc_high_buffer_q <= PC_HIGH_BUFFER_RST;
    end else if (wr_en && hit(avs_address, IDX_PC_HIGH_BUFFER)) begin
      pc_high_buffer_q <= {wd[PCH_SPARE], wd[1:0]};
    end
  end

  // Counter high bits follow the buffer only on a counter load
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pc_high_bits <= PC_HI_RST;
    end else if (pc_load) begin
      pc_high_bits <= pc_high_buffer_q[1:0];
    end
  end

  // Read mux; unmapped addresses and unimplemented bits read zero
  always_comb begin
    rd_d = 8'h00;
    if (hit(avs_address, IDX_FLAGS)) begin
      rd_d = flags_q;
    end else if (hit(avs_address, IDX_INDIRECT)) begin
      rd_d = indirect_q;
    end else if (hit(avs_address, IDX_PORT)) begin
      rd_d = {port_spare_q, (port_latch & latch_sel) | (pin_level & ~latch_sel)};
    end else if (hit(avs_address, IDX_POWER)) begin
      rd_d = power_q;
    end else if (hit(avs_address, IDX_WAKE)) begin
      rd_d = {2'h0, wake_q};
    end else if (hit(avs_address, IDX_PC_HIGH_BUFFER)) begin
      rd_d = {pc_high_buffer_q[2], 5'h00, pc_high_buffer_q[1:0]};
    end else if (hit(avs_address, IDX_PULLDN)) begin
      rd_d = {pulldn_q, 4'h0};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_q <= avs_read & ~rd_ack_q;
      if (avs_read && !rd_ack_q) begin
        avs_readdata <= {24'h00_0000, rd_d};
      end
    end
  end

  assign flags_out = flags_q;
  assign ctrl.bank_select = flags_q[FLG_BANK_HI:FLG_BANK_LO];
  assign ctrl.indirect_index = indirect_q[6:0];
  assign ctrl.watchdog_enable = power_q[PWR_WDT];
  assign ctrl.low_voltage_detect_enable = power_q[PWR_LVD];
  assign ctrl.low_voltage_reset_enable = power_q[PWR_LVR];
  assign ctrl.pin_wakeup_bit = wake_q;
  assign ctrl.pulldown_off_bit = pulldn_q;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_carry_sub;
    alu_req.valid && alu_req.op == CSB_OP_SUB && alu_req.a >= alu_req.b
      |=> flags_q[FLG_CARRY];
  endproperty
  a_carry_sub: assert property (p_carry_sub) else $error("carry not set on sub");

  property p_nibble_add;
    alu_req.valid && alu_req.op == CSB_OP_ADD
      && ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}) < 5'h10
      |=> !flags_q[FLG_NIBBLE];
  endproperty
  a_nibble_add: assert property (p_nibble_add) else $error("nibble carry wrong");

  property p_zero;
    alu_req.valid && alu_req.op == CSB_OP_LOGIC
      |=> flags_q[FLG_ZERO] == ($past(alu_req.logic_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sleep;
    sleep_exec |=> !flags_q[FLG_SLEEP_N] && flags_q[FLG_WDT_N] == !$past(wdt_timeout);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

  property p_wdt;
    wdt_timeout |=> !flags_q[FLG_WDT_N];
  endproperty
  a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");

  property p_port_write;
    wr_en && hit(avs_address, IDX_PORT) |=> port_latch == $past(avs_writedata[5:0]);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port latch not loaded");

  sequence s_code1;
    nvm_unlock_code_write && nvm_unlock_code == UNLOCK_CODE1 && lock_q == CSB_LK_LOCKED;
  endsequence
  sequence s_code2;
    nvm_unlock_code_write && nvm_unlock_code == UNLOCK_CODE2 && !nvm_write_instruction;
  endsequence
  sequence s_code3;
    nvm_unlock_code_write && nvm_unlock_code == UNLOCK_CODE3 && !nvm_write_instruction;
  endsequence
  property p_unlock;
    s_code1 ##1 s_code2 ##1 s_code3 |=> !power_q[PWR_LOCK];
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock sequence failed");

  property p_accept_locked;
    power_q[PWR_LOCK] |-> !nvm_write_accept;
  endproperty
  a_accept_locked: assert property (p_accept_locked) else $error("write while locked");

  property p_pc_load;
    pc_load |=> pc_high_bits == $past(pc_high_buffer_q[1:0]);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc high bits not loaded");

  property p_pc_hold;
    !pc_load |=> $stable(pc_high_bits);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc high bits moved");

  property p_toerr_ro;
    wr_en && hit(avs_address, IDX_POWER) && !nvm_timeout_event && !nvm_write_accept
      |=> $stable(toerr_q);
  endproperty
  a_toerr_ro: assert property (p_toerr_ro) else $error("timeout flag written");

  property p_read_wait;
    avs_read && !rd_ack_q |-> avs_waitrequest ##1 (!avs_read || !avs_waitrequest);
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule : csb_sfr_bank

// file: tb_csb_sfr_bank.sv
// Self-checking bench for the core special function register bank
`timescale 1ns/10ps
module tb_csb_sfr_bank;
  import csb_pkg::*;
  logic core_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  csb_alu_req_s alu_req;
  logic sleep_exec, watchdog_clear_instruction, wdt_timeout, pc_load;
  logic [1:0] pc_high_bits;
  logic [7:0] flags_out, nvm_unlock_code;
  logic [1:0] pch;
  logic [5:0] pin_in, pin_out_en, port_latch;
  logic port_readback_option, nvm_timeout_option, nvm_timeout_event;
  logic nvm_unlock_code_write, nvm_write_instruction, nvm_write_accept;
  csb_ctrl_s ctrl;
  int error_cnt, checked;
  // Model of every register index; unmapped ones stay zero
  logic [7:0] m [16];
  logic [3:0] tbl [9] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'h5, 4'hc};
  logic [4:0] evt [7] = '{5'h01, 5'h04, 5'h01, 5'h02, 5'h05, 5'h03, 5'h04};

  csb_sfr_bank #(.PIN_W(6)) u_dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .alu_req, .sleep_exec,
    .watchdog_clear_instruction, .wdt_timeout, .pc_load, .pc_high_bits, .flags_out, .pin_in,
    .pin_out_en, .port_readback_option, .port_latch, .nvm_timeout_option, .nvm_timeout_event,
    .nvm_unlock_code_write, .nvm_unlock_code, .nvm_write_instruction, .nvm_write_accept, .ctrl);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [7:0] wmask(input logic [3:0] idx);
    case (idx)
      4'h3, 4'h4, 4'h6: wmask = 8'hff;
      4'h8: wmask = 8'hfc;
      4'h9: wmask = 8'h3f;
      4'ha: wmask = 8'h83;
      4'hb: wmask = 8'hf0;
      default: wmask = 8'h00;
    endcase
  endfunction : wmask

  function automatic logic [7:0] exp_rd(input logic [3:0] idx);
    logic [7:0] v;
    v = m[idx];
    if (idx == IDX_PORT) begin
      for (int i = 0; i < 6; i++) begin
        v[i] = (pin_out_en[i] && port_readback_option) ? m[idx][i] : pin_in[i];
      end
    end
    return v;
  endfunction : exp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [3:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_write <= 1'b1;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    if (be[0]) m[idx] = (m[idx] & ~wmask(idx)) | (d & wmask(idx));
  endtask : bus_wr

  task automatic rd_chk(input logic [3:0] idx);
    @(posedge core_clk);
    avs_read <= 1'b1;
    avs_address <= {idx, 2'b00};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    chk(avs_readdata, {24'h0, exp_rd(idx)}, "register read");
    avs_read <= 1'b0;
  endtask : rd_chk

  task automatic outs();
    chk(32'(ctrl), 32'({m[3][7:6], m[4][6:0], m[8][7], m[8][5], m[8][3], m[9][5:0],
      m[11][7:4]}), "control outputs");
    chk(32'(flags_out), 32'(m[3]), "flags");
    chk(32'(port_latch), 32'(m[6][5:0]), "port latch");
  endtask : outs

  // Event bits: clear, sleep, watchdog timeout, counter load, write timeout
  task automatic ev(input logic [4:0] e);
    @(posedge core_clk);
    {nvm_timeout_event, pc_load, wdt_timeout, sleep_exec, watchdog_clear_instruction} <= e;
    @(posedge core_clk);
    {nvm_timeout_event, pc_load, wdt_timeout, sleep_exec, watchdog_clear_instruction} <= 5'h0;
    if (e[0]) m[3][4:3] = 2'b11;
    if (e[1]) m[3][4:3] = 2'b10;
    if (e[2]) m[3][4] = 1'b0;
    if (e[3]) pch = m[10][1:0];
    if (e[4] && nvm_timeout_option) m[8][1] = 1'b1;
    @(negedge core_clk);
  endtask : ev

  // Codes back to back, strobe held high across all three
  task automatic unlock(input logic [7:0] last);
    @(posedge core_clk);
    nvm_unlock_code_write <= 1'b1;
    nvm_unlock_code <= UNLOCK_CODE1;
    @(posedge core_clk);
    nvm_unlock_code <= UNLOCK_CODE2;
    @(posedge core_clk);
    nvm_unlock_code <= last;
    @(posedge core_clk);
    nvm_unlock_code_write <= 1'b0;
    m[8][0] = (last === UNLOCK_CODE3) ? 1'b0 : 1'b1;
    rd_chk(IDX_POWER);
  endtask : unlock

  task automatic wr_instr();
    @(posedge core_clk);
    nvm_write_instruction <= 1'b1;
    @(negedge core_clk);
    chk(32'(nvm_write_accept), {31'h0, ~m[8][0]}, "write accept");
    if (m[8][0] == 1'b0) m[8][1:0] = 2'b01;
    @(posedge core_clk);
    nvm_write_instruction <= 1'b0;
  endtask : wr_instr

  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end

  initial begin
    logic [7:0] a, b, r;
    logic [3:0] idx;
    int o, s;
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    alu_req = '0;
    {sleep_exec, watchdog_clear_instruction, wdt_timeout, pc_load} = 4'h0;
    {pin_in, pin_out_en, port_readback_option, nvm_timeout_option} = '0;
    {nvm_timeout_event, nvm_unlock_code_write, nvm_unlock_code, nvm_write_instruction} = '0;
    foreach (m[i]) m[i] = 8'h00;
    m[3] = 8'h18;
    m[8] = 8'h89;
    m[9] = 8'h3f;
    m[11] = 8'hf0;
    pch = 2'b00;
    void'($urandom(32'h1075f39c));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) rd_chk(4'(i));
    outs();
    chk(32'(pc_high_bits), 32'h0, "counter high bits");
    $display("test reset values done");
    repeat (40) begin
      idx = tbl[$urandom % 9];
      bus_wr(idx, 8'($urandom), {3'($urandom), 1'($urandom % 4 != 0)});
      rd_chk(idx);
      outs();
    end
    $display("test register access done");
    repeat (40) begin
      o = $urandom % 3;
      a = 8'($urandom);
      b = ($urandom % 4 == 0) ? a : 8'($urandom);
      r = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      @(posedge core_clk);
      alu_req <= '{1'b1, csb_alu_op_e'(o), a, b, r};
      @(posedge core_clk);
      alu_req.valid <= 1'b0;
      if (o == 0) begin
        s = a + b;
        m[3][0] = s > 255;
        m[3][1] = (a[3:0] + b[3:0]) > 15;
        r = 8'(s);
      end else if (o == 1) begin
        m[3][0] = a >= b;
        m[3][1] = a[3:0] >= b[3:0];
        r = a - b;
      end
      m[3][2] = (r == 8'h00);
      @(negedge core_clk);
      chk(32'(flags_out), 32'(m[3]), "arithmetic flags");
    end
    $display("test arithmetic flags done");
    foreach (evt[i]) begin
      ev(evt[i]);
      chk(32'(flags_out), 32'(m[3]), "reset cause flags");
    end
    repeat (3) begin
      bus_wr(IDX_PC_HIGH_BUFFER, 8'($urandom), 4'h1);
      chk(32'(pc_high_bits), 32'(pch), "no load yet");
      ev(5'h08);
      chk(32'(pc_high_bits), 32'(pch), "counter high bits");
      bus_wr(IDX_PC_HIGH_BUFFER, ~m[10], 4'h1);
      chk(32'(pc_high_bits), {30'h0, ~m[10][1:0]}, "held without load");
      ev(5'h08);
    end
    $display("test events done");
    repeat (10) begin
      @(posedge core_clk);
      pin_in <= 6'($urandom);
      pin_out_en <= 6'($urandom);
      port_readback_option <= 1'($urandom);
      bus_wr(IDX_PORT, 8'($urandom), 4'h1);
      repeat (6) @(posedge core_clk);
      rd_chk(IDX_PORT);
      outs();
    end
    $display("test port done");
    wr_instr();
    unlock(8'h55);
    wr_instr();
    unlock(UNLOCK_CODE3);
    bus_wr(IDX_POWER, 8'h00, 4'h1);
    rd_chk(IDX_POWER);
    wr_instr();
    rd_chk(IDX_POWER);
    ev(5'h10);
    rd_chk(IDX_POWER);
    nvm_timeout_option <= 1'b1;
    ev(5'h10);
    rd_chk(IDX_POWER);
    bus_wr(IDX_POWER, 8'hff, 4'h1);
    rd_chk(IDX_POWER);
    unlock(UNLOCK_CODE3);
    wr_instr();
    rd_chk(IDX_POWER);
    $display("test nonvolatile lock done");
    end_sim();
  end
endmodule : tb_csb_sfr_bank
